/* src/meter_regs_pkg.sv */
package meter_regs_pkg;
    // Register map and access widths
    localparam int        ADDR_W          = 12;
    localparam int        DATA_W          = 8;
    localparam logic [11:0] STATUS_OFFSET = 12'h000;
    localparam logic [11:0] MODE0_OFFSET  = 12'h001;
    localparam logic [11:0] VIRT_BASE     = 12'h800;
    localparam logic [11:0] FW_VER_OFFSET = 12'hC00;
    localparam logic [11:0] TEMP_OFFSET   = 12'hC01;

    // Global status field positions
    localparam int STAT_CRYSTAL_FAIL_BIT = 6;
    localparam int STAT_POR_BIT          = 5;
    localparam int STAT_WDT_BIT          = 4;
    localparam int STAT_PHASE_SEQ_BIT    = 2;
    localparam int STAT_PULSE_TWO_BIT    = 1;
    localparam int STAT_PULSE_ONE_BIT    = 0;

    // Operating mode zero field positions
    localparam int MODE_EXT_CLK_BIT      = 4;
    localparam int MODE_RESTART_BIT      = 3;
    localparam int MODE_DSP_DISABLE_BIT  = 2;
    localparam int MODE_LOW_POWER_BIT    = 1;

    // Reset values and writable masks
    localparam logic [7:0] STATUS_RESET  = 8'h00;
    localparam logic [7:0] MODE0_RESET   = 8'h00;
    localparam logic [7:0] MODE0_WR_MASK = 8'h1E;

    // Software restart sequencer states
    typedef enum logic [1:0] {
        RESTART_IDLE  = 2'b01,
        RESTART_PULSE = 2'b10
    } restart_state_t;
endpackage : meter_regs_pkg

/* src/metering_global_status_mode_regs.sv */
`timescale 1ns/1ps
// How it works
// - Writes to the computed-result region are ignored; it is read-only.
// - Status bit 6 shows crystal failure, core running on ring oscillator.
// - Status bit 5 shows the last reset came from power-on detection.
// - Status bit 4 shows the last reset came from watchdog expiry.
// - Status bit 2 is 0 for A-B-C order, 1 for A-C-B.
// - Phase order only means something when all three voltages exist.
// - Status bit 1 is 1 when second pulse quantity is negative.
// - Status bit 0 is 1 when first pulse quantity is negative.
// - Mode bit 4 disables crystal and uses crystal pin as clock input.
// - Mode bit 3 restarts firmware from its reset vector.
// - Software restart leaves hardware peripherals and registers untouched.
// - The restart bit clears itself once the restart has been issued.
// - Mode bit 2 stops signal processing; supervisory work continues.
// - Mode bit 1 moves core clock to the nominal 1MHz ring oscillator.
module metering_global_status_mode_regs
    import meter_regs_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              reset_i,
    input  wire logic [ADDR_W-1:0] reg_addr_i,
    input  wire logic              reg_wr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    output logic                   reg_rvalid_o,
    input  wire logic              crystal_failed_i,
    input  wire logic              por_cause_i,
    input  wire logic              wdt_cause_i,
    input  wire logic              all_three_voltages_i,
    input  wire logic              phase_sequence_reversed_i,
    input  wire logic              pulse_out_one_reverse_i,
    input  wire logic              pulse_out_two_reverse_i,
    input  wire logic [DATA_W-1:0] firmware_version_value_i,
    input  wire logic [DATA_W-1:0] raw_die_temperature_i,
    output logic                   external_clock_select_o,
    output logic                   software_restart_o,
    output logic                   signal_processing_disable_o,
    output logic                   low_power_clock_select_o
);
    logic           released_q;
    logic [3:0]     live_q;
    logic [7:0]     mode_q;
    logic [7:0]     mode_d;
    restart_state_t state_q;
    restart_state_t state_d;
    logic           por_flag;
    logic           wdt_flag;
    logic [7:0]     status_word;
    logic [7:0]     read_mux;
    logic           wr_status;
    logic           wr_mode;
    logic           capture;

    // Address decode; anything at or above the virtual base is read-only
    // virtual region read-only
    assign wr_status = reg_wr_i && (reg_addr_i == STATUS_OFFSET);
    assign wr_mode   = reg_wr_i && (reg_addr_i == MODE0_OFFSET);
    // Reset cause straps are caught on the first edge after release
    assign capture   = !released_q;

    // Release marker, so the cause inputs never feed an async reset path
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            released_q <= 1'b0;
        end else begin
            released_q <= 1'b1;
        end
    end

    sticky_flag u_por_flag (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .set_i     (capture && por_cause_i),
        .clear_i   (wr_status && !reg_wdata_i[STAT_POR_BIT]),
        .flag_o    (por_flag)
    );

    sticky_flag u_wdt_flag (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .set_i     (capture && wdt_cause_i),
        .clear_i   (wr_status && !reg_wdata_i[STAT_WDT_BIT]),
        .flag_o    (wdt_flag)
    );

    // Live status levels are registered once; they are not host-writable
    // crystal fail level
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            live_q <= 4'h0;
        end else begin
            live_q <= {crystal_failed_i,
                       phase_sequence_reversed_i && all_three_voltages_i,
                       pulse_out_two_reverse_i,
                       pulse_out_one_reverse_i};
        end
    end

    // Status image; reserved bits 7 and 3 are held at zero
    // phase order bit
    always_comb begin
        status_word                        = STATUS_RESET;
        status_word[STAT_CRYSTAL_FAIL_BIT] = live_q[3];
        status_word[STAT_POR_BIT]          = por_flag;
        status_word[STAT_WDT_BIT]          = wdt_flag;
        status_word[STAT_PHASE_SEQ_BIT]    = live_q[2];
        status_word[STAT_PULSE_TWO_BIT]    = live_q[1];
        status_word[STAT_PULSE_ONE_BIT]    = live_q[0];
    end

    // Read selection; unmapped addresses read as zero
    assign read_mux =
        (reg_addr_i == STATUS_OFFSET) ? status_word :
        (reg_addr_i == MODE0_OFFSET)  ? mode_q :
        (reg_addr_i == FW_VER_OFFSET) ? firmware_version_value_i :
        (reg_addr_i == TEMP_OFFSET)   ? raw_die_temperature_i : 8'h00;

    // Mode next value; a fresh write of the restart bit beats the self-clear
    // reserved bits masked
    always_comb begin
        mode_d = mode_q;
        if (state_q == RESTART_PULSE) begin
            mode_d[MODE_RESTART_BIT] = 1'b0;
        end
        if (wr_mode) begin
            mode_d = reg_wdata_i & MODE0_WR_MASK;
        end
    end

    // Restart sequencer: one pulse per request, nothing else is reset
    // restart request pulse
    always_comb begin
        state_d = RESTART_IDLE;
        case (state_q)
            RESTART_IDLE: begin
                if (mode_q[MODE_RESTART_BIT]) begin
                    state_d = RESTART_PULSE;
                end
            end
            RESTART_PULSE: state_d = RESTART_IDLE;
            default:       state_d = RESTART_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mode_q  <= MODE0_RESET;
            state_q <= RESTART_IDLE;
        end else begin
            mode_q  <= mode_d;
            state_q <= state_d;
        end
    end

    // Outputs straight from flops, following the mode register
    // external clock select
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            external_clock_select_o     <= 1'b0;
            signal_processing_disable_o <= 1'b0;
            low_power_clock_select_o    <= 1'b0;
            software_restart_o          <= 1'b0;
            reg_rdata_o                 <= 8'h00;
            reg_rvalid_o                <= 1'b0;
        end else begin
            external_clock_select_o     <= mode_d[MODE_EXT_CLK_BIT];
            signal_processing_disable_o <= mode_d[MODE_DSP_DISABLE_BIT];
            low_power_clock_select_o    <= mode_d[MODE_LOW_POWER_BIT];
            software_restart_o          <= (state_d == RESTART_PULSE);
            reg_rdata_o                 <= reg_rd_i ? read_mux : 8'h00;
            reg_rvalid_o                <= reg_rd_i;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    // Outside a restart pulse, so the self-clear cannot move the mode word
    property p_virtual_ro;
        reg_wr_i && reg_addr_i >= VIRT_BASE && state_q == RESTART_IDLE
        |=> $stable(mode_q);
    endproperty
    a_virtual_ro: assert property (p_virtual_ro)
        else $error("write to virtual region changed mode");

    property p_crystal;
        crystal_failed_i |-> ##1 status_word[STAT_CRYSTAL_FAIL_BIT];
    endproperty
    a_crystal: assert property (p_crystal)
        else $error("crystal fail not reported");

    property p_por_hold;
        por_flag && !wr_status |=> por_flag;
    endproperty
    a_por_hold: assert property (p_por_hold)
        else $error("power-on flag lost without clear");

    property p_wdt_clear;
        wr_status && !reg_wdata_i[STAT_WDT_BIT] && !capture |=> !wdt_flag;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog flag not cleared");

    property p_phase_gate;
        !all_three_voltages_i |=> !status_word[STAT_PHASE_SEQ_BIT];
    endproperty
    a_phase_gate: assert property (p_phase_gate)
        else $error("phase order shown without three voltages");

    property p_pulse_dir;
        ##1 status_word[1:0] ==
            $past({pulse_out_two_reverse_i, pulse_out_one_reverse_i});
    endproperty
    a_pulse_dir: assert property (p_pulse_dir)
        else $error("pulse direction bits wrong");

    property p_restart;
        wr_mode && reg_wdata_i[MODE_RESTART_BIT] && state_q == RESTART_IDLE
        |=> !software_restart_o ##1 software_restart_o ##1
            (!software_restart_o && !mode_q[MODE_RESTART_BIT]) [*2];
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart pulse or self-clear wrong");

    property p_mode_out;
        wr_mode |=> low_power_clock_select_o ==
            $past(reg_wdata_i[MODE_LOW_POWER_BIT])
            && external_clock_select_o == $past(reg_wdata_i[MODE_EXT_CLK_BIT]);
    endproperty
    a_mode_out: assert property (p_mode_out)
        else $error("mode outputs do not follow write");

    property p_reserved;
        reg_rvalid_o && $past(reg_addr_i) == STATUS_OFFSET
        |-> reg_rdata_o[7] == 1'b0 && reg_rdata_o[3] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bit read nonzero");

    c_restart: cover property (software_restart_o);
    c_por_clr: cover property (por_flag ##1 !por_flag);
    c_low_power_clock_select:   cover property (low_power_clock_select_o);
endmodule : metering_global_status_mode_regs

/* src/sticky_flag.sv */
`timescale 1ns/1ps
// Sticky flag: hardware set wins over a clear in the same cycle
module sticky_flag (
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic set_i,
    input  wire logic clear_i,
    output logic      flag_o
);
    logic flag_d;

    // Set has priority so no event is lost during a host clear
    assign flag_d = set_i ? 1'b1 : (clear_i ? 1'b0 : flag_o);

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            flag_o <= 1'b0;
        end else begin
            flag_o <= flag_d;
        end
    end
endmodule : sticky_flag

/* test/host_model.sv */
`timescale 1ns/1ps
// Host side of the register port, one strobe per access
module host_model
    import meter_regs_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [DATA_W-1:0] reg_rdata_i,
    input  wire logic              reg_rvalid_i,
    output logic      [ADDR_W-1:0] reg_addr_o,
    output logic                   reg_wr_o,
    output logic      [DATA_W-1:0] reg_wdata_o,
    output logic                   reg_rd_o
);
    // Quiet bus at time zero
    initial begin
        reg_addr_o = 12'h000;
        reg_wdata_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // Held through the taking edge; idle lines then show the inverse
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d,
                          output logic [DATA_W-1:0] q);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = w;
        reg_rd_o = !w;
        @(negedge ref_clk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
        q = reg_rvalid_i ? reg_rdata_i : {DATA_W{1'bx}};
    endtask : access

    task automatic clear_causes();
        logic [DATA_W-1:0] q;
        access(1'b1, STATUS_OFFSET, 8'h00, q);
    endtask : clear_causes
endmodule : host_model

/* test/metering_global_status_mode_regs_tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end end
module metering_global_status_mode_regs_tb_top
    import meter_regs_pkg::*;
;
    logic              ref_clk_i, reset_i, rd, wr, rv, ext, sw, dsp, lp;
    logic              xf, por, wdt, all3, ph, p1, p2;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wd, rdat, fw, temp;
    int                err_total, num_checks;

    // Clock and time-zero input values
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        {reset_i, xf, por, wdt, all3, ph, p1, p2} = 8'h80;
        fw = 8'h5A;
        temp = 8'hA5;
    end

    metering_global_status_mode_regs dut_u (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd),
        .reg_rdata_o(rdat), .reg_rvalid_o(rv), .crystal_failed_i(xf),
        .por_cause_i(por), .wdt_cause_i(wdt), .all_three_voltages_i(all3),
        .phase_sequence_reversed_i(ph), .pulse_out_one_reverse_i(p1),
        .pulse_out_two_reverse_i(p2), .firmware_version_value_i(fw),
        .raw_die_temperature_i(temp), .external_clock_select_o(ext),
        .software_restart_o(sw), .signal_processing_disable_o(dsp),
        .low_power_clock_select_o(lp));
    host_model host_u (
        .ref_clk_i(ref_clk_i), .reg_rdata_i(rdat), .reg_rvalid_i(rv),
        .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wd),
        .reg_rd_o(rd));

    task automatic rd_chk(input string nm, input logic [11:0] a,
                          input logic [7:0] e);
        logic [7:0] q;
        host_u.access(1'b0, a, 8'h00, q);
        `CHK(nm, e, q)
    endtask : rd_chk
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        logic [7:0] q;
        host_u.access(1'b1, a, d, q);
    endtask : wr_reg
    // Cause straps must be steady across release, so reset is at negedge
    task automatic do_reset();
        @(negedge ref_clk_i);
        reset_i = 1'b1;
        repeat (5) @(negedge ref_clk_i);
        reset_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
    endtask : do_reset

    task automatic t_reset_vals();
        do_reset();
        rd_chk("status", STATUS_OFFSET, STATUS_RESET);
        rd_chk("mode", MODE0_OFFSET, MODE0_RESET);
        `CHK("outs", 4'h0, {ext, sw, dsp, lp})
        $display("test reset_vals done");
    endtask : t_reset_vals

    // Straps stay high after release: only the first edge may capture
    task automatic t_cause();
        logic [7:0] e;
        for (int i = 0; i < 2; i++) begin
            por = (i == 0);
            wdt = (i == 1);
            e = (i == 0) ? 8'h20 : 8'h10;
            do_reset();
            rd_chk("cause", STATUS_OFFSET, e);
            wr_reg(STATUS_OFFSET, 8'hFF);
            rd_chk("ones", STATUS_OFFSET, e);
            host_u.clear_causes();
            rd_chk("cleared", STATUS_OFFSET, 8'h00);
        end
        {por, wdt} = 2'b00;
        $display("test cause done");
    endtask : t_cause

    task automatic t_live();
        logic [7:0] e[5] = '{8'h40, 8'h01, 8'h02, 8'h04, 8'h00};
        for (int k = 0; k < 5; k++) begin
            {xf, p1, p2} = {k == 0, k == 1, k == 2};
            {all3, ph} = {k == 3, k >= 3};
            repeat (2) @(negedge ref_clk_i);
            rd_chk("live", STATUS_OFFSET, e[k]);
        end
        {xf, all3, ph} = 3'b000;
        $display("test live done");
    endtask : t_live

    task automatic t_mode();
        wr_reg(MODE0_OFFSET, 8'hFF);
        `CHK("mode outs", 3'h7, {ext, dsp, lp})
        repeat (3) @(negedge ref_clk_i);
        rd_chk("mode rd", MODE0_OFFSET, 8'h16);
        wr_reg(MODE0_OFFSET, 8'h00);
        `CHK("mode off", 3'h0, {ext, dsp, lp})
        $display("test mode done");
    endtask : t_mode

    task automatic t_restart();
        logic [3:0] n;
        n = 4'h0;
        wr_reg(MODE0_OFFSET, 8'h02);
        // host requests a restart, keeping the low power bit set
        wr_reg(MODE0_OFFSET, 8'h0A);
        repeat (6) begin
            @(negedge ref_clk_i);
            n = n + {3'h0, sw};
        end
        `CHK("pulses", 4'h1, n)
        `CHK("lp kept", 1'b1, lp)
        rd_chk("mode kept", MODE0_OFFSET, 8'h02);
        rd_chk("no por", STATUS_OFFSET, 8'h00);
        wr_reg(MODE0_OFFSET, 8'h00);
        $display("test restart done");
    endtask : t_restart

    task automatic t_readonly();
        wr_reg(FW_VER_OFFSET, 8'h00);
        wr_reg(VIRT_BASE, 8'h12);
        wr_reg(12'h002, 8'hFF);
        rd_chk("fw", FW_VER_OFFSET, 8'h5A);
        rd_chk("temp", TEMP_OFFSET, 8'hA5);
        rd_chk("virt", VIRT_BASE, 8'h00);
        rd_chk("unmapped", 12'h123, 8'h00);
        rd_chk("mode", MODE0_OFFSET, 8'h00);
        rd_chk("status", STATUS_OFFSET, 8'h00);
        $display("test readonly done");
    endtask : t_readonly

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    // Whole run is about 110 cycles; this cuts a hang
    initial begin
        repeat (3000) @(posedge ref_clk_i);
        err_total++;
        report_and_stop();
    end
    initial begin
        t_reset_vals();
        t_cause();
        t_live();
        t_mode();
        t_restart();
        t_readonly();
        report_and_stop();
    end
endmodule : metering_global_status_mode_regs_tb_top
